// ### rtl/mtlb_unit.sv
`timescale 1ns/1ps
`default_nettype none
module mtlb_unit
    import mtlb_pkg::*;
#(
    parameter int FA_ENTRIES = 8,
    parameter int SA_SETS = 16
) (
    input wire logic clk,                       // core clock, 10 MHz
    input wire logic rst_n,                     // async reset, active low
    input wire logic [VA_W-1:0] regVa,          // register address (va)
    input wire logic [7:0] regAsi,              // address space of access
    input wire logic [63:0] regWdata,           // write data
    input wire logic regWr,                     // write strobe
    input wire logic regRd,                     // read strobe
    output logic [63:0] regRdata,               // read data, cycle after strobe
    input wire logic lookupValid,               // translation request
    input wire logic [VA_W-1:0] lookupVa,       // address to translate
    input wire logic microMiss,                 // request follows a micro buffer miss
    output logic lookupHit,                     // translation found
    output logic [PA_W-1:0] lookupPa,           // translated address
    output logic lookupMulti,                   // multiple fa match seen behind a micro buffer miss
    input wire logic faultValid,                // data fault reported
    input wire logic [VA_W-1:0] faultVa,        // faulting address
    input wire logic [FSTAT_W-1:0] faultStatus, // fault cause
    input wire logic faultJmplAlign,            // misaligned jump-and-link or return
    input wire logic addrMaskBit,               // 32-bit address masking
    output logic irq                            // level interrupt
);
    localparam int SI_W = $clog2(SA_SETS);

    mtlb_fa_if fa ();

    // ========================================
    // registers
    logic [VPN_W-1:0] tag_q;
    logic [TSIZE_W-1:0] tsize_q;
    logic [VA_W-1:0] faultAddr_q;
    logic [FSTAT_W-1:0] faultStat_q;
    logic [NUM_EV-1:0] istat_q, istat_d, imask_q;
    logic [5:0] esel_q;
    logic [63:0] regRdata_q;
    logic irq_q;
    logic lookupHit_q, lookupMulti_q;
    logic [PA_W-1:0] lookupPa_q;
    // set associative buffer, two ways
    logic [SA_SETS-1:0] saValid_q [2];
    logic [VPN_W-1:0] saVpn_q [SA_SETS][2];
    logic [PPN_W-1:0] saPpn_q [SA_SETS][2];
    logic [SA_SETS-1:0] saLru_q;

    // ========================================
    // register decode: only va bits 17:0 take part
    wire asiHit = (regAsi == ASI_INSTR) || (regAsi == ASI_DATA);
    wire [17:0] off = regVa[17:0];
    wire tagWr = regWr && asiHit && (off == OFF_TAG);
    wire dataInWr = regWr && asiHit && (off == OFF_DATA_IN);
    wire tsizeWr = regWr && asiHit && (off == OFF_TSIZE);
    wire istatWr = regWr && asiHit && (off == OFF_ISTAT);
    wire imaskWr = regWr && asiHit && (off == OFF_IMASK);
    wire eselWr = regWr && asiHit && (off == OFF_ESEL);
    wire edataRd = regRd && asiHit && (off == OFF_EDATA);

    // ========================================
    // entry being written: page size, lock, masked page numbers
    wire mtlb_size_t wSize = mtlb_size_t'(regWdata[E_SIZE+1:E_SIZE]);
    wire wLock = regWdata[E_LOCK];
    wire [8:0] wMask = mtlb_ofs_mask(wSize);
    // offset bits of large pages are thrown away so they cannot alias
    wire [PPN_W-1:0] wPpn = {regWdata[40:22], regWdata[21:13] & ~wMask};
    wire [VPN_W-1:0] wVpn = {tag_q[VPN_W-1:9], tag_q[8:0] & ~wMask};
    // locked or large pages land in the fully associative buffer
    wire placeFa = wLock || (wSize != SZ_8K);
    wire saWr = dataInWr && !placeFa;
    wire [SI_W-1:0] wSet = wVpn[SI_W-1:0];
    wire wBoth = saValid_q[0][wSet] && saValid_q[1][wSet];
    wire saWay = !saValid_q[0][wSet] ? 1'b0 : (!saValid_q[1][wSet] ? 1'b1 : saLru_q[wSet]);

    assign fa.wrEn = dataInWr && placeFa;
    assign fa.wrVpn = wVpn;
    assign fa.wrPpn = wPpn;
    assign fa.wrSize = wSize;
    assign fa.wrLock = wLock;
    assign fa.lkEn = lookupValid;
    assign fa.lkVpn = lookupVa[VA_W-1:OFS_W];
    assign fa.rdIdx = esel_q[2:0];

    // ========================================
    // set associative lookup
    wire [VPN_W-1:0] lVpn = lookupVa[VA_W-1:OFS_W];
    wire [SI_W-1:0] lSet = lVpn[SI_W-1:0];
    wire saHit0 = saValid_q[0][lSet] && (saVpn_q[lSet][0] == lVpn);
    wire saHit1 = saValid_q[1][lSet] && (saVpn_q[lSet][1] == lVpn);
    wire saHit = saHit0 || saHit1;
    wire [PPN_W-1:0] saPpn = saHit1 ? saPpn_q[lSet][1] : saPpn_q[lSet][0];
    // big pages take their low page-number bits from the va
    wire [8:0] lMask = mtlb_ofs_mask(fa.lkSize);
    wire [PPN_W-1:0] faPpn = {fa.lkPpn[PPN_W-1:9],
                              (fa.lkPpn[8:0] & ~lMask) | (lVpn[8:0] & lMask)};
    wire [PA_W-1:0] hitPa = {(fa.lkHit ? faPpn : saPpn), lookupVa[OFS_W-1:0]};
    // duplicates are only looked for behind a micro buffer miss
    wire multiEv = lookupValid && microMiss && fa.lkMulti;

    // ========================================
    // fault capture
    wire faultTake = faultValid && !faultJmplAlign;
    wire [VA_W-1:0] faultAddr_d = addrMaskBit ? {32'h0000_0000, faultVa[31:0]} : faultVa;

    // ========================================
    // events and interrupt; a new event beats a same-cycle clear
    wire [NUM_EV-1:0] ev = {dataInWr && placeFa && fa.full, multiEv, faultTake};
    assign istat_d = (istat_q & ~(istatWr ? regWdata[NUM_EV-1:0] : '0)) | ev;

    // ========================================
    // read mux; the entry word drops the cv bit, it is not supported
    wire saSelWay = esel_q[4];
    wire [SI_W-1:0] saSelSet = esel_q[SI_W-1:0];
    wire [63:0] saWord = mtlb_word(saValid_q[saSelWay][saSelSet], SZ_8K,
                                   saPpn_q[saSelSet][saSelWay], 1'b0);
    wire [63:0] saTag = {saVpn_q[saSelSet][saSelWay], 13'h0000};
    wire [63:0] eData = esel_q[5] ? saWord : fa.rdWord;
    wire [63:0] eTag = esel_q[5] ? saTag : {fa.rdVpn, 13'h0000};
    wire [63:0] rdMux =
        !asiHit ? 64'h0 :
        (off == OFF_TAG) ? {tag_q, 13'h0000} :
        (off == OFF_TSIZE) ? {60'h0, tsize_q} :
        (off == OFF_FADDR) ? faultAddr_q :
        (off == OFF_FSTAT) ? {48'h0, faultStat_q} :
        (off == OFF_ISTAT) ? {61'h0, istat_q} :
        (off == OFF_IMASK) ? {61'h0, imask_q} :
        (off == OFF_ESEL) ? {58'h0, esel_q} :
        (off == OFF_EDATA) ? eData :
        (off == OFF_ETAG) ? eTag : 64'h0;

    mtlb_fa_buffer #(
        .ENTRIES(FA_ENTRIES)
    ) u_fa (
        .clk(clk),
        .rst_n(rst_n),
        .fa(fa)
    );

    // ========================================
    // software registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tag_q <= '0;
            tsize_q <= '0;
            imask_q <= '0;
            esel_q <= ESEL_RST;
        end else begin
            if (tagWr) begin
                tag_q <= regWdata[VA_W-1:OFS_W];
            end
            if (tsizeWr) begin
                tsize_q <= regWdata[TSIZE_W-1:0];
            end
            if (imaskWr) begin
                imask_q <= regWdata[NUM_EV-1:0];
            end
            if (eselWr) begin
                esel_q <= regWdata[5:0];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_q <= '0;
        end else begin
            regRdata_q <= regRd ? rdMux : 64'h0;
        end
    end

    // fault registers hold through ignored faults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultAddr_q <= '0;
            faultStat_q <= '0;
        end else if (faultTake) begin
            faultAddr_q <= faultAddr_d;
            faultStat_q <= faultStatus;
        end
    end

    // status and interrupt level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            istat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            istat_q <= istat_d;
            irq_q <= |(istat_d & imask_q);
        end
    end

    // lookup results, registered so every output is a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lookupHit_q <= 1'b0;
            lookupPa_q <= '0;
            lookupMulti_q <= 1'b0;
        end else begin
            lookupHit_q <= lookupValid && (fa.lkHit || saHit);
            lookupMulti_q <= multiEv;
            if (lookupValid) begin
                lookupPa_q <= hitPa;
            end
        end
    end

    // set associative buffer: lru bit names the way to replace next
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            saValid_q[0] <= '0;
            saValid_q[1] <= '0;
            saLru_q <= '0;
        end else begin
            if (lookupValid && saHit && !(saWr && wSet == lSet)) begin
                saLru_q[lSet] <= ~saHit1;
            end
            if (saWr) begin
                saValid_q[saWay][wSet] <= 1'b1;
                saLru_q[wSet] <= ~saWay;
            end
        end
    end

    // entry contents carry no reset; valid bits guard them
    always_ff @(posedge clk) begin
        if (saWr) begin
            saVpn_q[wSet][saWay] <= wVpn;
            saPpn_q[wSet][saWay] <= wPpn;
        end
    end

    assign regRdata = regRdata_q;
    assign lookupHit = lookupHit_q;
    assign lookupPa = lookupPa_q;
    assign lookupMulti = lookupMulti_q;
    assign irq = irq_q;

    // ========================================
    // checks
    property p_lock_fa;
        @(posedge clk) disable iff (!rst_n)
        (dataInWr && wLock) |-> (fa.wrEn && fa.wrLock);
    endproperty
    a_lock_fa: assert property (p_lock_fa)
        else $error("locked entry not sent to full buffer");

    property p_small_sa;
        @(posedge clk) disable iff (!rst_n)
        (dataInWr && !wLock && wSize == SZ_8K) |=> saValid_q[$past(saWay)][$past(wSet)];
    endproperty
    a_small_sa: assert property (p_small_sa)
        else $error("small unlocked entry not placed in set buffer");

    property p_sa_lru;
        @(posedge clk) disable iff (!rst_n)
        (saWr && wBoth) |=> (saLru_q[$past(wSet)] == ~$past(saWay));
    endproperty
    a_sa_lru: assert property (p_sa_lru)
        else $error("set buffer lru not updated");

    sequence s_sa_read;
        edataRd && esel_q[5];
    endsequence
    property p_sa_lock_zero;
        @(posedge clk) disable iff (!rst_n)
        s_sa_read |=> (regRdata[E_LOCK] == 1'b0) && (regRdata[E_CV] == 1'b0);
    endproperty
    a_sa_lock_zero: assert property (p_sa_lock_zero)
        else $error("set buffer lock bit reads nonzero");

    property p_tsize;
        @(posedge clk) disable iff (!rst_n)
        tsizeWr ##1 (regRd && asiHit && off == OFF_TSIZE && !tsizeWr)
            |=> (regRdata[3:0] == $past(regWdata[3:0], 2));
    endproperty
    a_tsize: assert property (p_tsize)
        else $error("table size field did not read back");

    property p_pa_high_zero;
        @(posedge clk) disable iff (!rst_n)
        edataRd |=> (regRdata[46:41] == 6'h00);
    endproperty
    a_pa_high_zero: assert property (p_pa_high_zero)
        else $error("entry pa bits 46:41 not zero");

    property p_am_zero;
        @(posedge clk) disable iff (!rst_n)
        (faultTake && addrMaskBit) |=> (faultAddr_q[63:32] == 32'h0000_0000);
    endproperty
    a_am_zero: assert property (p_am_zero)
        else $error("fault address upper half not cleared");

    property p_jump_and_link_instr_keep;
        @(posedge clk) disable iff (!rst_n)
        (faultValid && faultJmplAlign) |=> ($stable(faultAddr_q) && $stable(faultStat_q));
    endproperty
    a_jump_and_link_instr_keep: assert property (p_jump_and_link_instr_keep)
        else $error("fault registers changed on jump misalign");

    property p_multi_miss;
        @(posedge clk) disable iff (!rst_n)
        lookupMulti |-> $past(lookupValid && microMiss);
    endproperty
    a_multi_miss: assert property (p_multi_miss)
        else $error("multiple hit flagged without micro miss");
endmodule
`default_nettype wire

// ### rtl/mtlb_pkg.sv
package mtlb_pkg;
    // ========================================
    // widths
    localparam int VA_W = 64;
    localparam int VPN_W = 51;            // va bits 63:13
    localparam int PPN_W = 28;            // pa bits 40:13
    localparam int PA_W = 41;
    localparam int OFS_W = 13;
    localparam int TSIZE_W = 4;
    localparam int FSTAT_W = 16;
    localparam int NUM_EV = 3;
    // ========================================
    // register offsets, decoded from va bits 17:0 only
    localparam logic [17:0] OFF_TAG = 18'h00000;
    localparam logic [17:0] OFF_DATA_IN = 18'h00008;
    localparam logic [17:0] OFF_TSIZE = 18'h00010;
    localparam logic [17:0] OFF_FADDR = 18'h00018;
    localparam logic [17:0] OFF_FSTAT = 18'h00020;
    localparam logic [17:0] OFF_ISTAT = 18'h00028;
    localparam logic [17:0] OFF_IMASK = 18'h00030;
    localparam logic [17:0] OFF_ESEL = 18'h00038;
    localparam logic [17:0] OFF_EDATA = 18'h00040;
    localparam logic [17:0] OFF_ETAG = 18'h00048;
    localparam logic [7:0] ASI_INSTR = 8'h55;
    localparam logic [7:0] ASI_DATA = 8'h5D;
    // ========================================
    // entry word fields
    localparam int E_VALID = 63;
    localparam int E_SIZE = 61;
    localparam int E_LOCK = 6;
    localparam int E_CV = 4;
    // interrupt status bits
    localparam int EV_FAULT = 0;
    localparam int EV_MULTI = 1;
    localparam int EV_FULL = 2;
    localparam logic [5:0] ESEL_RST = 6'h00;

    typedef enum logic [1:0] {
        SZ_8K = 2'b00,
        SZ_64K = 2'b01,
        SZ_512K = 2'b10,
        SZ_4M = 2'b11
    } mtlb_size_t;

    // page-number bits that are really page offset for a size
    function automatic logic [8:0] mtlb_ofs_mask(input mtlb_size_t s);
        case (s)
            SZ_64K: mtlb_ofs_mask = 9'h007;
            SZ_512K: mtlb_ofs_mask = 9'h03F;
            SZ_4M: mtlb_ofs_mask = 9'h1FF;
            default: mtlb_ofs_mask = 9'h000;
        endcase
    endfunction

    function automatic logic [63:0] mtlb_word(input logic v, input mtlb_size_t s,
                                              input logic [PPN_W-1:0] p, input logic l);
        mtlb_word = {v, s, 14'h0000, 6'h00, p, 6'h00, l, 6'h00};
    endfunction
endpackage

// ### rtl/mtlb_fa_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mtlb_fa_if;
    import mtlb_pkg::*;
    logic wrEn;
    logic [VPN_W-1:0] wrVpn;
    logic [PPN_W-1:0] wrPpn;
    mtlb_size_t wrSize;
    logic wrLock;
    logic full;
    logic lkEn;
    logic [VPN_W-1:0] lkVpn;
    logic lkHit;
    logic lkMulti;
    logic [PPN_W-1:0] lkPpn;
    mtlb_size_t lkSize;
    logic [2:0] rdIdx;
    logic [63:0] rdWord;
    logic [VPN_W-1:0] rdVpn;
    modport ctl (output wrEn, wrVpn, wrPpn, wrSize, wrLock, lkEn, lkVpn, rdIdx,
                 input full, lkHit, lkMulti, lkPpn, lkSize, rdWord, rdVpn);
    modport buff (input wrEn, wrVpn, wrPpn, wrSize, wrLock, lkEn, lkVpn, rdIdx,
                  output full, lkHit, lkMulti, lkPpn, lkSize, rdWord, rdVpn);
endinterface
`default_nettype wire

// ### rtl/mtlb_fa_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module mtlb_fa_buffer
    import mtlb_pkg::*;
#(
    parameter int ENTRIES = 8
) (
    input wire logic clk,      // core clock
    input wire logic rst_n,    // async reset, active low
    mtlb_fa_if.buff fa         // port to the control logic
);
    localparam int LG = $clog2(ENTRIES);
    logic [ENTRIES-1:0] valid_q, lock_q, hitVec;
    logic [VPN_W-1:0] vpn_q [ENTRIES];
    logic [PPN_W-1:0] ppn_q [ENTRIES];
    mtlb_size_t size_q [ENTRIES];
    logic [ENTRIES-2:0] tree_q, tree_d;
    logic [LG-1:0] plru, victim, hitIdx, touchIdx;
    logic haveInvalid, haveFree;
    logic [LG-1:0] firstInvalid, firstFree;

    // ========================================
    // match: low page-number bits are don't-care for big pages
    for (genvar i = 0; i < ENTRIES; i++) begin : g_match
        wire [8:0] msk = mtlb_ofs_mask(size_q[i]);
        assign hitVec[i] = valid_q[i] &&
            ((vpn_q[i] | {{(VPN_W-9){1'b0}}, msk}) == (fa.lkVpn | {{(VPN_W-9){1'b0}}, msk}));
    end
    assign fa.lkHit = |hitVec;
    assign fa.lkMulti = (hitVec & (hitVec - 1'b1)) != '0;
    assign fa.lkPpn = ppn_q[hitIdx];
    assign fa.lkSize = size_q[hitIdx];
    // entry contents carry no reset, so an empty slot's data word is forced to all zeros; its tag is not
    assign fa.rdWord = valid_q[fa.rdIdx] ?
        mtlb_word(1'b1, size_q[fa.rdIdx], ppn_q[fa.rdIdx], lock_q[fa.rdIdx]) : 64'h0;
    assign fa.rdVpn = vpn_q[fa.rdIdx];
    // all locked: nothing may be evicted, the write is refused
    assign fa.full = !haveFree;
    assign victim = haveInvalid ? firstInvalid : (!lock_q[plru] ? plru : firstFree);
    assign touchIdx = fa.wrEn ? victim : hitIdx;

    // ========================================
    // tree walk for the pseudo-lru pick, and priority scans
    always_comb begin
        int node;
        node = 0;
        plru = '0;
        hitIdx = '0;
        haveInvalid = 1'b0;
        haveFree = 1'b0;
        firstInvalid = '0;
        firstFree = '0;
        for (int l = 0; l < LG; l++) begin
            plru[LG-1-l] = tree_q[node];
            node = 2 * node + 1 + int'(tree_q[node]);
        end
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (hitVec[i]) begin
                hitIdx = LG'(i);
            end
            if (!valid_q[i]) begin
                haveInvalid = 1'b1;
                firstInvalid = LG'(i);
            end
            if (!(valid_q[i] && lock_q[i])) begin
                haveFree = 1'b1;
                firstFree = LG'(i);
            end
        end
    end

    // point the tree away from the entry just used
    always_comb begin
        int node;
        node = 0;
        tree_d = tree_q;
        if ((fa.wrEn && haveFree) || (fa.lkEn && fa.lkHit)) begin
            for (int l = 0; l < LG; l++) begin
                tree_d[node] = ~touchIdx[LG-1-l];
                node = 2 * node + 1 + int'(touchIdx[LG-1-l]);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= '0;
            lock_q <= '0;
            tree_q <= '0;
        end else begin
            tree_q <= tree_d;
            if (fa.wrEn && haveFree) begin
                valid_q[victim] <= 1'b1;
                lock_q[victim] <= fa.wrLock;
                vpn_q[victim] <= fa.wrVpn;
                ppn_q[victim] <= fa.wrPpn;
                size_q[victim] <= fa.wrSize;
            end
        end
    end

    property p_no_locked_victim;
        @(posedge clk) disable iff (!rst_n)
        (fa.wrEn && haveFree && !haveInvalid) |-> !lock_q[victim];
    endproperty
    a_no_locked_victim: assert property (p_no_locked_victim)
        else $error("locked entry chosen for replacement");
endmodule
`default_nettype wire

// ### test/mtlb_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module mtlb_unit_test;
    import mtlb_pkg::*;
    // ========================================
    // stimulus and observed signals
    logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, lookupValid = 1'b0;
    logic microMiss = 1'b0, faultValid = 1'b0, faultJmplAlign = 1'b0, addrMaskBit = 1'b0;
    logic [63:0] regVa = '0, regWdata = '0, lookupVa = '0, faultVa = '0, regRdata, r, d;
    logic [7:0] regAsi = 8'h55, forceAsi = 8'h00;
    logic [15:0] faultStatus = '0;
    logic [40:0] lookupPa;
    logic lookupHit, lookupMulti, irq;
    logic [27:0] pA, pB, pC;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    mtlb_unit u_dut (.clk(clk), .rst_n(rst_n), .regVa(regVa), .regAsi(regAsi),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .lookupValid(lookupValid), .lookupVa(lookupVa), .microMiss(microMiss),
        .lookupHit(lookupHit), .lookupPa(lookupPa), .lookupMulti(lookupMulti),
        .faultValid(faultValid), .faultVa(faultVa), .faultStatus(faultStatus),
        .faultJmplAlign(faultJmplAlign), .addrMaskBit(addrMaskBit), .irq(irq));
    always #50 clk = ~clk;
    // hang guard: whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ========================================
    // shared tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // expected entry word built bit by bit from the field layout
    function automatic logic [63:0] ew(input logic [1:0] s, input logic [27:0] p, input logic l);
        ew = '0;
        ew[63] = 1'b1;
        ew[62:61] = s;
        ew[40:13] = p;
        ew[6] = l;
    endfunction
    // one register cycle; upper va bits are random noise the decoder must ignore
    task automatic acc(input logic w, input logic [17:0] off, input logic [63:0] wd,
                       output logic [63:0] rv);
        logic [63:0] hi;
        hi = {$urandom, $urandom};
        @(posedge clk);
        regVa <= {hi[63:18], off};
        regAsi <= (forceAsi != 8'h00) ? forceAsi : (hi[0] ? ASI_INSTR : ASI_DATA);
        regWdata <= wd;
        regWr <= w;
        regRd <= ~w;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1 rv = regRdata;
    endtask
    task automatic ent(input logic [63:0] va, input logic [63:0] word);
        logic [63:0] d;
        acc(1'b1, OFF_TAG, va, d);
        acc(1'b1, OFF_DATA_IN, word, d);
    endtask
    task automatic lk(input logic [63:0] va, input logic hit, input logic [40:0] pa);
        @(posedge clk);
        lookupValid <= 1'b1;
        lookupVa <= va;
        microMiss <= 1'b1;
        @(posedge clk);
        lookupValid <= 1'b0;
        #1 chk({63'h0, lookupHit}, {63'h0, hit}, "lookup hit");
        if (hit) chk({23'h0, lookupPa}, {23'h0, pa}, "lookup pa");
        chk({63'h0, lookupMulti}, 64'h0, "no duplicate match");
    endtask
    task automatic flt(input logic [63:0] va, input logic [15:0] st, input logic j, input logic am);
        @(posedge clk);
        faultValid <= 1'b1;
        faultVa <= va;
        faultStatus <= st;
        faultJmplAlign <= j;
        addrMaskBit <= am;
        @(posedge clk);
        faultValid <= 1'b0;
        faultJmplAlign <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ========================================
    // main sequence
    initial begin
        void'($urandom(32'h74C1D739));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({62'h0, irq, lookupHit}, 64'h0, "reset outputs");
        r = {32'h0, $urandom};
        acc(1'b1, OFF_TSIZE, r, d);
        acc(1'b0, OFF_TSIZE, 64'h0, pA);
        chk(pA, {60'h0, r[3:0]}, "table size");
        forceAsi = 8'h54;
        acc(1'b0, OFF_TSIZE, 64'h0, r);
        chk(r, 64'h0, "foreign space");
        forceAsi = 8'h00;
        $display("test regs done");
        pA = 28'($urandom);
        ent(64'h0000_0040_0000_2000, ew(2'd0, pA, 1'b1) | 64'h0000_7E00_0000_0000);
        acc(1'b1, OFF_ESEL, 64'h0, r);
        acc(1'b0, OFF_EDATA, 64'h0, r);
        chk(r, ew(2'd0, pA, 1'b1), "locked entry");
        lk(64'h0000_0040_0000_2123, 1'b1, {pA, 13'h0123});
        pC = 28'($urandom);
        ent(64'h0000_0000_0003_4000, ew(2'd0, pC, 1'b0));
        acc(1'b1, OFF_ESEL, 64'h1, r);
        acc(1'b0, OFF_EDATA, 64'h0, r);
        chk(r, 64'h0, "small page kept out of fa");
        lk(64'h0000_0000_0003_4ABC, 1'b1, {pC, 13'h0ABC});
        pB = 28'($urandom) | 28'h7;
        ent(64'h0000_0000_1234_0000, ew(2'd1, pB, 1'b0));
        acc(1'b0, OFF_EDATA, 64'h0, r);
        chk(r, ew(2'd1, {pB[27:3], 3'h0}, 1'b0), "large page");
        lk(64'h0000_0000_1234_BEEF, 1'b1, {pB[27:3], 16'hBEEF});
        $display("test placement done");
        acc(1'b1, OFF_IMASK, 64'h0, r);
        flt(64'hDEAD_BEEF_1234_5678, 16'h00A5, 1'b0, 1'b1);
        acc(1'b0, OFF_FADDR, 64'h0, r);
        chk(r, 64'h0000_0000_1234_5678, "masked address");
        flt(64'h1111_2222_3333_4444, 16'h0F0F, 1'b1, 1'b0);
        acc(1'b0, OFF_FADDR, 64'h0, r);
        chk(r, 64'h0000_0000_1234_5678, "address after jump_and_link_instr");
        acc(1'b0, OFF_FSTAT, 64'h0, r);
        chk(r, 64'h0000_0000_0000_00A5, "status after jump_and_link_instr");
        chk({63'h0, irq}, 64'h0, "masked irq");
        acc(1'b1, OFF_IMASK, 64'h7, r);
        // the level output is a flop: it follows a new mask one cycle later
        @(posedge clk);
        #1 chk({63'h0, irq}, 64'h1, "irq raised");
        acc(1'b1, OFF_ISTAT, 64'h1, r);
        #1 chk({63'h0, irq}, 64'h0, "irq cleared");
        flt(64'h1111_2222_3333_4444, 16'h0F0F, 1'b0, 1'b0);
        acc(1'b0, OFF_FADDR, 64'h0, r);
        chk(r, 64'h1111_2222_3333_4444, "full address");
        acc(1'b1, OFF_ISTAT, 64'h1, r);
        $display("test faults done");
        // six locked fill slots 2..7, the seventh evicts the unlocked large page; eighth is refused
        for (int i = 0; i < 8; i++) ent(64'h0000_0000_0100_0000 + 64'(i << 13),
                                        ew(2'd0, 28'(i), 1'b1));
        acc(1'b0, OFF_ISTAT, 64'h0, r);
        chk(r, 64'h4, "locked full status");
        #1 chk({63'h0, irq}, 64'h1, "locked full irq");
        lk(64'h0000_0040_0000_2000, 1'b1, {pA, 13'h0});
        lk(64'h0000_0000_0100_C000, 1'b1, {28'h6, 13'h0});
        lk(64'h0000_0000_0100_E000, 1'b0, 41'h0);
        $display("test lock done");
        stop_test();
    end
endmodule
`default_nettype wire
